// >>> logic/cmd_engine.v
`timescale 1ns/1ps
`include "cmd_defs.vh"
module cmd_engine #(
  parameter MOTORS = 3
) (
  // Clock and reset.
  input  wire              clk,
  input  wire              rst_n,
  // Command byte stream.
  input  wire              rx_valid,
  input  wire [7:0]        rx_byte,
  input  wire              rx_from_program,
  // Reply byte stream.
  output wire              tx_valid,
  output reg  [7:0]        tx_byte,
  input  wire              tx_ready,
  // Motion status.
  input  wire [MOTORS-1:0] pos_reached,
  // Indexed register loads from other commands.
  input  wire              x_load,
  input  wire [31:0]       x_load_value,
  input  wire              accu_load,
  input  wire [31:0]       accu_load_value,
  // Register views.
  output reg  [31:0]       accu,
  output reg  [31:0]       x_reg
);
  localparam S_RX    = 3'h0;
  localparam S_READ  = 3'h1;
  localparam S_WAIT  = 3'h2;
  localparam S_TX    = 3'h3;
  localparam S_EVENT = 3'h4;

  reg [2:0]        state;
  reg [3:0]        count;
  reg [7:0]        sum;
  reg [7:0]        addr_byte;
  reg [7:0]        cmd;
  reg [7:0]        typ;
  reg [31:0]       value;
  reg [7:0]        rsp_status;
  reg [7:0]        rsp_cmd;
  reg [31:0]       rsp_value;
  reg              is_event;
  reg [MOTORS-1:0] armed_mask;
  reg              armed_persist;
  reg              armed_once;
  reg              move_seen;
  reg [MOTORS-1:0] reached_d;
  reg [MOTORS-1:0] pend_hit;
  wire [31:0]      ram_rdata;
  wire             ram_we;

  function [7:0] reply_byte;
    input [3:0]  idx;
    input [7:0]  st;
    input [7:0]  cm;
    input [31:0] vl;
    input [7:0]  ad;
    begin
      case (idx)
        4'h0:    reply_byte = `HOST_ADDR;
        4'h1:    reply_byte = ad;
        4'h2:    reply_byte = st;
        4'h3:    reply_byte = cm;
        4'h4:    reply_byte = vl[31:24];
        4'h5:    reply_byte = vl[23:16];
        4'h6:    reply_byte = vl[15:8];
        default: reply_byte = vl[7:0];
      endcase
    end
  endfunction

  wire frame_done = (state == S_RX) && rx_valid && (count == `FRAME_LAST);
  // [RULE12] checksum compare
  wire sum_ok     = (rx_byte == sum);
  // [RULE2] index range check
  wire x_ok       = ~x_reg[31] && (x_reg <= `INDEX_MAX);
  // [RULE3] indexed store
  assign ram_we   = frame_done && sum_ok && (cmd == `OP_ACCU_TO_INDEXED) && x_ok;
  wire [MOTORS-1:0] reached_rise = pos_reached & ~reached_d;
  wire              arm_live     = (armed_persist || armed_once) && move_seen;
  wire [MOTORS-1:0] hit          = reached_rise & armed_mask & {MOTORS{arm_live}};
  // A hit that lands while a frame other than a position request is in flight is kept until the engine is idle.
  wire [MOTORS-1:0] hit_all      = pend_hit | hit;
  wire event_fire = (|hit_all) && (count == 4'h0);
  assign tx_valid = (state == S_TX);

  // [RULE12] next reply byte and running sum
  wire [3:0] cnt_nx  = count + 4'h1;
  wire [7:0] sum_nx  = sum + reply_byte(count, rsp_status, rsp_cmd, rsp_value, addr_byte);
  wire [7:0] tx_next = (cnt_nx == `FRAME_LAST) ? sum_nx
                       : reply_byte(cnt_nx, rsp_status, rsp_cmd, rsp_value, addr_byte);

  // [RULE13] user variable store
  var_ram #(.WIDTH(32), .DEPTH(256), .AW(8)) u_vars (
    .clk   (clk),
    .we    (ram_we),
    .addr  (x_reg[7:0]),
    .wdata (accu),
    .rdata (ram_rdata)
  );

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state         <= S_RX;
      count         <= 4'h0;
      sum           <= 8'h00;
      addr_byte     <= 8'h00;
      cmd           <= 8'h00;
      typ           <= 8'h00;
      value         <= 32'h0000_0000;
      rsp_status    <= 8'h00;
      rsp_cmd       <= 8'h00;
      rsp_value     <= 32'h0000_0000;
      is_event      <= 1'b0;
      armed_mask    <= {MOTORS{1'b0}};
      armed_persist <= 1'b0;
      armed_once    <= 1'b0;
      move_seen     <= 1'b0;
      reached_d     <= {MOTORS{1'b0}};
      pend_hit      <= {MOTORS{1'b0}};
      accu          <= 32'h0000_0000;
      x_reg         <= 32'h0000_0000;
      tx_byte       <= 8'h00;
    end else begin
      reached_d <= pos_reached;
      pend_hit  <= hit_all;
      if (x_load) begin
        x_reg <= x_load_value;
      end
      if (accu_load) begin
        accu <= accu_load_value;
      end
      case (state)
        S_RX: begin
          if (rx_valid) begin
            sum   <= sum + rx_byte;
            count <= count + 4'h1;
            if (count == 4'h0) begin
              addr_byte <= rx_byte;
            end else if (count == `BYTE_CMD) begin
              cmd <= rx_byte;
            end else if (count == `BYTE_TYPE) begin
              typ <= rx_byte;
            end else if (count == `BYTE_V3) begin
              value[31:24] <= rx_byte;
            end else if (count == `BYTE_V2) begin
              value[23:16] <= rx_byte;
            end else if (count == `BYTE_V1) begin
              value[15:8] <= rx_byte;
            end else if (count == `BYTE_V0) begin
              value[7:0] <= rx_byte;
            end
            if (frame_done) begin
              sum        <= 8'h00;
              count      <= 4'h0;
              rsp_cmd    <= cmd;
              rsp_value  <= 32'h0000_0000;
              rsp_status <= `ST_OK;
              is_event   <= 1'b0;
              state      <= S_TX;
              if (!sum_ok) begin
                // [RULE12] bad checksum rejected
                rsp_status <= `ST_BAD_CHECKSUM;
              end else if (cmd == `OP_GET_INDEXED) begin
                // [RULE1] [RULE4] read then reply
                state <= x_ok ? S_READ : S_TX;
              end else if (cmd == `OP_ACCU_TO_INDEXED) begin
                // [RULE4] reply OK, value undefined
                rsp_value <= 32'h0000_0000;
              end else if (cmd >= `OP_USER_FIRST && cmd <= `OP_USER_LAST) begin
                // [RULE5] user function hook
                rsp_value <= value;
              end else if (cmd == `OP_POS_REACHED) begin
                if (rx_from_program) begin
                  // [RULE10] direct mode only
                  rsp_status <= `ST_BAD_COMMAND;
                end else begin
                  // [RULE7] [RULE8] arm with mask
                  armed_mask    <= value[MOTORS-1:0];
                  armed_persist <= (typ[0] == 1'b1);
                  armed_once    <= (typ[0] == 1'b0);
                  move_seen     <= 1'b0;
                  pend_hit      <= {MOTORS{1'b0}};
                  // [RULE11] immediate reply echoes mask
                  rsp_value     <= {24'h000000, value[7:0]};
                end
              end else if (cmd == `OP_MOVE_TO_POS) begin
                move_seen <= 1'b1;
              end else begin
                rsp_status <= `ST_BAD_COMMAND;
              end
            end
          end else if (event_fire) begin
            // [RULE6] delayed second reply
            rsp_status <= `ST_EVENT;
            rsp_cmd    <= `OP_POS_REACHED;
            rsp_value  <= {{(32-MOTORS){1'b0}}, hit_all};
            pend_hit   <= {MOTORS{1'b0}};
            is_event   <= 1'b1;
            armed_once <= 1'b0;
            move_seen  <= 1'b0;
            state      <= S_EVENT;
          end
        end
        S_READ: begin
          state <= S_WAIT;
        end
        S_WAIT: begin
          // [RULE1] accumulator load
          accu  <= ram_rdata;
          state <= S_TX;
        end
        S_EVENT: begin
          state <= S_TX;
        end
        S_TX: begin
          if (tx_ready) begin
            if (count == `FRAME_LAST) begin
              count <= 4'h0;
              sum   <= 8'h00;
              state <= S_RX;
            end else begin
              count <= count + 4'h1;
              sum   <= sum + reply_byte(count, rsp_status, rsp_cmd, rsp_value, addr_byte);
            end
          end
        end
        default: begin
          state <= S_RX;
        end
      endcase
      if (state == S_TX) begin
        tx_byte <= tx_ready ? tx_next : tx_byte;
      end else begin
        tx_byte <= reply_byte(4'h0, rsp_status, rsp_cmd, rsp_value, addr_byte);
      end
    end
  end

endmodule

// >>> logic/var_ram.v
`timescale 1ns/1ps
module var_ram #(
  parameter WIDTH = 32,
  parameter DEPTH = 256,
  parameter AW    = 8
) (
  // Clock.
  input  wire             clk,
  // Access.
  input  wire             we,
  input  wire [AW-1:0]    addr,
  input  wire [WIDTH-1:0] wdata,
  output reg  [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  // Contents have no reset, as in a real RAM; variables start undefined.
  always @(posedge clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule

// >>> shared/cmd_defs.vh
// Notes on behaviour
// [RULE1] Opcode 0x38 loads accumulator from indexed variable.
// [RULE2] X outside 0..255 executes nothing.
// [RULE3] Opcode 0x39 stores accumulator to indexed variable.
// [RULE4] Indexed commands ignore fields, reply status 100.
// [RULE5] Eight user-function opcodes reply status 100.
// [RULE6] Position request: immediate reply, later event reply.
// [RULE7] Value field is motor bit mask.
// [RULE8] Type 0 next move only; type 1 every move.
// [RULE9] Host should prefer type 1.
// [RULE10] Position request only as direct host command.
// [RULE11] Replies status 0x64 then 0x80, echo 0x8A.
// [RULE12] Last frame byte is modulo-256 byte sum.
// [RULE13] 256 variables of 32 bits, accumulator, signed X.
`ifndef CMD_DEFS_VH
`define CMD_DEFS_VH
`define OP_GET_INDEXED     8'h38
`define OP_ACCU_TO_INDEXED 8'h39
`define OP_USER_FIRST      8'h40
`define OP_USER_LAST       8'h47
`define OP_POS_REACHED     8'h8A
`define OP_MOVE_TO_POS     8'h04
`define ST_OK              8'h64
`define ST_EVENT           8'h80
`define ST_BAD_CHECKSUM    8'h01
`define ST_BAD_COMMAND     8'h02
`define FRAME_LAST         4'h8
`define BYTE_CMD           4'h1
`define BYTE_TYPE          4'h2
`define BYTE_V3            4'h4
`define BYTE_V2            4'h5
`define BYTE_V1            4'h6
`define BYTE_V0            4'h7
`define INDEX_MAX          32'h0000_00FF
`define HOST_ADDR          8'h02
`endif

// >>> tb/cmd_engine_asserts.sv
`timescale 1ns/1ps
`include "cmd_defs.vh"
module cmd_engine_asserts #(
  parameter MOTORS = 3
) (
  // Watched ports.
  input logic        clk,
  input logic        rst_n,
  input logic        rx_valid,
  input logic        tx_valid,
  input logic [7:0]  tx_byte,
  input logic        tx_ready,
  input logic        x_load,
  input logic        accu_load,
  input logic [31:0] accu,
  input logic [31:0] x_reg
);
  logic [3:0] rx_idx;
  logic [3:0] tx_idx;
  logic [7:0] sum;
  logic [7:0] st;
  ////////////////////////////////////////
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_idx <= 4'h0;
      tx_idx <= 4'h0;
      sum <= 8'h00;
      st <= 8'h00;
    end else begin
      if (rx_valid && !tx_valid)
        rx_idx <= (rx_idx == 4'h8) ? 4'h0 : rx_idx + 4'h1;
      if (tx_valid && tx_ready) begin
        tx_idx <= (tx_idx == 4'h8) ? 4'h0 : tx_idx + 4'h1;
        sum <= (tx_idx == 4'h8) ? 8'h00 : sum + tx_byte;
        if (tx_idx == 4'h2)
          st <= tx_byte;
      end
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_last;
    rx_valid && !tx_valid && rx_idx == 4'h8;
  endsequence
  property p_reply; s_last |-> ##[1:3] tx_valid; endproperty
  a_reply: assert property (p_reply) else $error("no reply after frame");
  property p_hold; tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte); endproperty
  a_hold: assert property (p_hold) else $error("reply byte dropped");
  property p_addr; $rose(tx_valid) && tx_idx == 4'h0 |-> tx_byte == `HOST_ADDR; endproperty
  a_addr: assert property (p_addr) else $error("bad host address");
  property p_status;
    tx_valid && tx_idx == 4'h2 |-> tx_byte inside {`ST_OK, `ST_EVENT, `ST_BAD_CHECKSUM, `ST_BAD_COMMAND};
  endproperty
  a_status: assert property (p_status) else $error("bad status");
  property p_echo; tx_valid && tx_idx == 4'h3 && st == `ST_EVENT |-> tx_byte == `OP_POS_REACHED; endproperty
  a_echo: assert property (p_echo) else $error("event echo wrong");
  property p_mask; tx_valid && tx_idx == 4'h7 && st == `ST_EVENT |-> (tx_byte >> MOTORS) == 8'h00; endproperty
  a_mask: assert property (p_mask) else $error("mask out of range");
  property p_sum; tx_valid && tx_idx == 4'h8 |-> tx_byte == sum; endproperty
  a_sum: assert property (p_sum) else $error("reply checksum wrong");
  property p_accu; !accu_load && x_reg[31:8] != 24'h0 |=> $stable(accu); endproperty
  a_accu: assert property (p_accu) else $error("accu moved on bad index");
  property p_x; !x_load |=> $stable(x_reg); endproperty
  a_x: assert property (p_x) else $error("index register moved");
endmodule
bind cmd_engine cmd_engine_asserts #(.MOTORS(MOTORS)) cmd_engine_asserts_i (.*);

// >>> tb/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock.
  input  logic       clk,
  // Command and reply streams.
  output logic       rx_valid,
  output logic [7:0] rx_byte,
  output logic       rx_from_program,
  input  logic       tx_valid,
  input  logic [7:0] tx_byte,
  output logic       tx_ready
);
  logic       slow = 1'b0;
  logic [3:0] n = 4'h0;
  logic [7:0] rep [0:8];
  initial begin
    rx_valid = 1'b0;
    rx_byte = 8'h00;
    rx_from_program = 1'b0;
    tx_ready = 1'b1;
  end
  // A slow host accepts every other cycle, so held bytes get exercised.
  always @(posedge clk) begin
    tx_ready <= slow ? ~tx_ready : 1'b1;
    if (tx_valid && tx_ready) begin
      rep[n] <= tx_byte;
      n <= n + 4'h1;
    end
  end
  task automatic send(input logic [7:0] op, typ, input logic [31:0] val, input logic bad, prog);
    logic [7:0] f [0:8];
    f = '{8'h01, op, typ, 8'h00, val[31:24], val[23:16], val[15:8], val[7:0], 8'h00};
    for (int i = 0; i < 8; i++)
      f[8] += f[i];
    f[8] += {7'h00, bad};
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_byte <= f[i];
      rx_from_program <= prog;
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_byte <= ~f[8];
  endtask
  task automatic wait_reply(output logic ok);
    ok = 1'b0;
    for (int i = 0; i < 300 && !ok; i++) begin
      @(posedge clk);
      ok = (n == 4'h9);
    end
    n <= 4'h0;
  endtask
endmodule

// >>> tb/testbench.sv
`timescale 1ns/1ps
`include "cmd_defs.vh"
module testbench;
  logic        clk = 1'b0, rst_n = 1'b0, ok;
  logic        rx_valid, rx_from_program, tx_valid, tx_ready, x_load = 1'b0, accu_load = 1'b0;
  logic [7:0]  rx_byte, tx_byte;
  logic [2:0]  pos_reached = 3'b000;
  logic [31:0] x_load_value = 32'h0, accu_load_value = 32'h0, accu, x_reg;
  int          n_fail = 0, n_compared = 0, cycles = 0;
  cmd_engine #(.MOTORS(3)) cmd_engine_i (.*);
  host_model host_i (.*);
  initial forever #2 clk = ~clk;
  ////////////////////////////////////////
  task automatic conclude;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic reply(input logic [7:0] st, op, input logic [31:0] v, input logic vchk);
    logic [7:0] s = 8'h00;
    host_i.wait_reply(ok);
    chk("reply", 1, ok);
    for (int i = 0; i < 8; i++) s += host_i.rep[i];
    chk("host", `HOST_ADDR, host_i.rep[0]);
    chk("target", 8'h01, host_i.rep[1]);
    chk("status", st, host_i.rep[2]);
    chk("command", op, host_i.rep[3]);
    chk("checksum", s, host_i.rep[8]);
    if (vchk) chk("value", v, {host_i.rep[4], host_i.rep[5], host_i.rep[6], host_i.rep[7]});
  endtask
  task automatic xfer(input logic [7:0] op, typ, input logic [31:0] val, input logic bad, prog,
                      input logic [7:0] st, input logic [31:0] v, input logic vchk);
    host_i.send(op, typ, val, bad, prog);
    reply(st, op, v, vchk);
  endtask
  task automatic load(input logic [31:0] x, a);
    @(posedge clk);
    x_load <= 1'b1;
    x_load_value <= x;
    accu_load <= 1'b1;
    accu_load_value <= a;
    @(posedge clk);
    x_load <= 1'b0;
    accu_load <= 1'b0;
  endtask
  task automatic rise(input logic [2:0] m);
    xfer(`OP_MOVE_TO_POS, 8'h00, 32'h0, 0, 0, `ST_OK, 0, 0);
    @(posedge clk);
    pos_reached <= m;
    repeat (4) @(posedge clk);
    pos_reached <= 3'b000;
  endtask
  ////////////////////////////////////////
  task automatic t_indexed;
    load(32'd255, 32'h1234_5678);
    xfer(`OP_ACCU_TO_INDEXED, 8'h5A, 32'hFFFF_FFFF, 0, 0, `ST_OK, 0, 0);
    load(32'd255, 32'h0);
    xfer(`OP_GET_INDEXED, 8'h00, 32'h0, 0, 0, `ST_OK, 0, 0);
    chk("accu", 32'h1234_5678, accu);
    chk("x_reg", 32'h0000_00FF, x_reg);
  endtask
  task automatic t_invalid;
    load(32'd256, 32'hA5A5_0001);
    xfer(`OP_GET_INDEXED, 8'h00, 32'h0, 0, 0, `ST_OK, 0, 0);
    chk("accu", 32'hA5A5_0001, accu);
    load(32'hFFFF_FFFF, 32'h0BAD);
    xfer(`OP_ACCU_TO_INDEXED, 8'h00, 32'h0, 0, 0, `ST_OK, 0, 0);
    load(32'd255, 32'h0);
    xfer(`OP_GET_INDEXED, 8'h00, 32'h0, 0, 0, `ST_OK, 0, 0);
    chk("accu", 32'h1234_5678, accu);
  endtask
  task automatic t_user;
    for (int i = 0; i < 8; i++)
      xfer(`OP_USER_FIRST + i[7:0], 8'h00, 32'hC0DE_0000 + i, 0, 0, `ST_OK, 32'hC0DE_0000 + i, 1);
  endtask
  task automatic t_event;
    xfer(`OP_POS_REACHED, 8'h00, 32'h5, 0, 0, `ST_OK, 32'h5, 1);
    rise(3'b001);
    reply(`ST_EVENT, `OP_POS_REACHED, 32'h1, 1);
    rise(3'b001);
    repeat (20) @(posedge clk);
    chk("silent", 0, host_i.n);
    host_i.slow <= 1'b1;
    xfer(`OP_POS_REACHED, 8'h01, 32'h5, 0, 0, `ST_OK, 32'h5, 1);
    rise(3'b010);
    repeat (20) @(posedge clk);
    chk("silent", 0, host_i.n);
    rise(3'b100);
    reply(`ST_EVENT, `OP_POS_REACHED, 32'h4, 1);
    rise(3'b100);
    reply(`ST_EVENT, `OP_POS_REACHED, 32'h4, 1);
    host_i.slow <= 1'b0;
  endtask
  task automatic t_refuse;
    xfer(`OP_GET_INDEXED, 8'h00, 32'h0, 1, 0, `ST_BAD_CHECKSUM, 0, 0);
    xfer(`OP_POS_REACHED, 8'h01, 32'h1, 0, 1, `ST_BAD_COMMAND, 0, 0);
    xfer(8'h48, 8'h00, 32'h0, 0, 0, `ST_BAD_COMMAND, 0, 0);
  endtask
  ////////////////////////////////////////
  // A hang in any handshake ends the run here.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_fail++;
      conclude;
    end
  end
  initial begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_indexed;
    t_invalid;
    t_user;
    t_event;
    t_refuse;
    conclude;
  end
endmodule
